// ### rtl/nvia_slave.v
/*
 I2C target access logic of a serial nonvolatile SRAM: array and control-register
 slaves, address counters, acknowledge decisions, write guard, power-loss save and
 power-up restore. Written array bytes pass a FIFO before they commit to storage.
 Assumes SCL/SDA come from outside the clock domain and SCL is far slower than ref_clk.
*/
// Operation
// R1: Write-protect pin high refuses every write and freezes the address counter.
// R2: Supply below threshold blocks access and starts the conditional power-loss save.
// R3: Skip power-loss save when nothing was written since last save or restore.
// R4: Master must disable power-loss save when no storage capacitor is fitted.
// R5: Supply rising starts restore; access stays disabled for the restore time.
// R6: Address LSB gives direction; writes carry word address then data.
// R7: Write goes on until stop, repeated start or a device NACK.
// R8: Address bytes not naming this device get no acknowledge.
// R9: Write to guarded array block: NACK after data, counter points there.
// R10: Invalid word address gets NACK after address; counter unchanged.
// R11: After a write NACK, ignore data until stop or repeated start.
// R12: Burst write reaching read-only ID is refused there, counter held.
// R13: Nonexistent register address draws NACK after address; counter kept.
// R14: Byte commits right after eighth data bit; good writes acknowledged.
// R15: Master aborts a write by stop or start before eighth bit.
// R16: Read drives SDA after address byte, starting past the last access.
// R17: Sequential reads advance counter and wrap after the final address.
// R18: Control burst read into nonexistent location continues from location zero.
// R19: Master ends reads by NACK then stop, or stop on ninth clock.
// R20: Array writes auto-increment and wrap to zero after the last location.
// R21: Random read loads counter from a write's address then repeated start.
// R22: Array address is two bytes, MSB first, top three bits ignored.
// R23: Block guard: 00 none, 01 top quarter, 10 top half, 11 all.
// R24: With serial lock set only command and memory-control locations are writable.
// R25: Command bytes decode to save, restore and sleep.
`timescale 1ns/1ps
`default_nettype none
`include "nvia_map.vh"
module nvia_slave #(
    parameter RESTORE_CYCLES = `NVIA_RESTORE_CYC
) (
    input wire ref_clk,
    input wire rst,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire write_protect,
    input wire supply_ok,
    output reg mem_busy,
    output reg save_start,
    output reg restore_start,
    output reg sleep_req,
    output reg power_loss_save_en
);
localparam ST_IDLE = 3'd0;
localparam ST_DEV = 3'd1;
localparam ST_ADDR = 3'd2;
localparam ST_WDATA = 3'd3;
localparam ST_RDATA = 3'd4;
localparam ST_ACK = 3'd5;
localparam ST_RACK = 3'd6;
localparam ST_IGNORE = 3'd7;

wire scl_s;
wire sda_s;
wire wp_s;
wire sup_s;
nvia_sync u_scl (.ref_clk(ref_clk), .rst(rst), .d(scl_in), .q(scl_s));
nvia_sync u_sda (.ref_clk(ref_clk), .rst(rst), .d(sda_in), .q(sda_s));
nvia_sync u_wp (.ref_clk(ref_clk), .rst(rst), .d(write_protect), .q(wp_s));
nvia_sync u_sup (.ref_clk(ref_clk), .rst(rst), .d(supply_ok), .q(sup_s));

reg scl_d;
reg sda_d;
reg sup_d;
wire scl_rise = scl_s && !scl_d;
wire scl_fall = !scl_s && scl_d;
wire start_cond = scl_s && scl_d && sda_d && !sda_s;
wire stop_cond = scl_s && scl_d && !sda_d && sda_s;

reg [7:0] array_mem [0:8191];
reg [7:0] serial_no [1:8];
reg [7:0] memctl;
reg [12:0] arr_ptr;
reg [7:0] reg_ptr;
reg [2:0] state;
reg [2:0] bit_cnt;
reg [7:0] shreg;
reg is_ctrl;
reg is_read;
reg [1:0] addr_cnt;
reg [12:0] addr_hold;
reg after_ack;
reg dirty;
reg [31:0] restore_cnt;
reg [7:0] rd_byte;

wire [1:0] guard = memctl[`NVIA_MEMCTL_BG_HI:`NVIA_MEMCTL_BG_LO];
wire lock = memctl[`NVIA_MEMCTL_LOCK];
wire [12:0] wr_addr = {addr_hold[12:8], shreg[7:0]};
// Identity bytes leave most significant first
wire [31:0] dev_id = `NVIA_DEVICE_ID;
wire [7:0] id_off = reg_ptr - `NVIA_REG_ID_FIRST;
wire [31:0] id_shift = dev_id << {id_off[1:0], 3'b000};

function arr_guarded;
    input [12:0] a;
    input [1:0] g;
    begin
        case (g)
            2'b01: arr_guarded = (a >= `NVIA_Q1_BASE); // R23
            2'b10: arr_guarded = (a >= `NVIA_Q2_BASE); // R23
            2'b11: arr_guarded = 1'b1; // R23
            default: arr_guarded = 1'b0;
        endcase
    end
endfunction

function reg_exists;
    input [7:0] a;
    begin
        reg_exists = (a <= `NVIA_REG_ID_LAST) || (a == `NVIA_REG_CMD);
    end
endfunction

function [7:0] reg_next;
    input [7:0] a;
    begin
        if (a >= `NVIA_REG_ID_LAST) begin
            reg_next = `NVIA_REG_MEMCTL; // R18
        end else begin
            reg_next = a + 8'h01;
        end
    end
endfunction

// Byte stream toward storage; commits are queued so slow storage can stall
reg fifo_in_valid;
reg [7:0] fifo_in_data;
reg [12:0] commit_addr;
wire fifo_in_ready;
wire [7:0] fifo_out_data;
wire fifo_out_valid;
wire store_ready = !mem_busy;
nvia_fifo #(.WIDTH(`NVIA_FIFO_WIDTH), .DEPTH(`NVIA_FIFO_DEPTH), .AW(`NVIA_FIFO_AW)) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_data(fifo_in_data),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(store_ready)
);
reg [12:0] drain_addr;
always @(posedge ref_clk) begin
    if (fifo_out_valid && store_ready) begin
        array_mem[drain_addr] <= fifo_out_data; // R14
    end
end
always @(posedge ref_clk) begin
    if (rst) begin
        drain_addr <= `NVIA_ADDR_ZERO;
    end else if (fifo_in_valid && fifo_in_ready && !fifo_out_valid) begin
        drain_addr <= commit_addr;
    end else if (fifo_out_valid && store_ready) begin
        drain_addr <= drain_addr + 13'h0001;
    end
end

always @* begin
    if (is_ctrl) begin
        if (reg_ptr == `NVIA_REG_MEMCTL) begin
            rd_byte = memctl;
        end else if (reg_ptr >= `NVIA_REG_ID_FIRST && reg_ptr <= `NVIA_REG_ID_LAST) begin
            rd_byte = id_shift[31:24];
        end else if (reg_ptr >= `NVIA_REG_SN_FIRST && reg_ptr <= `NVIA_REG_SN_LAST) begin
            rd_byte = serial_no[reg_ptr[3:0]];
        end else begin
            rd_byte = 8'h00;
        end
    end else begin
        rd_byte = array_mem[arr_ptr];
    end
end

always @(posedge ref_clk) begin
    if (rst) begin
        scl_d <= 1'b1;
        sda_d <= 1'b1;
        // Same level as the synchroniser's reset, so no false restore
        sup_d <= 1'b1;
        state <= ST_IDLE;
        bit_cnt <= 3'd0;
        shreg <= 8'h00;
        sda_out <= 1'b0;
        sda_oe <= 1'b0;
        is_ctrl <= 1'b0;
        is_read <= 1'b0;
        addr_cnt <= 2'd0;
        addr_hold <= `NVIA_ADDR_ZERO;
        after_ack <= 1'b0;
        arr_ptr <= `NVIA_ADDR_ZERO;
        reg_ptr <= `NVIA_REG_MEMCTL;
        memctl <= 8'h00;
        dirty <= 1'b0;
        mem_busy <= 1'b1;
        restore_cnt <= 32'd0;
        save_start <= 1'b0;
        restore_start <= 1'b0;
        sleep_req <= 1'b0;
        power_loss_save_en <= 1'b1;
        fifo_in_valid <= 1'b0;
        fifo_in_data <= 8'h00;
        commit_addr <= `NVIA_ADDR_ZERO;
    end else begin
        scl_d <= scl_s;
        sda_d <= sda_s;
        sup_d <= sup_s;
        save_start <= 1'b0;
        restore_start <= 1'b0;
        sleep_req <= 1'b0;
        fifo_in_valid <= 1'b0;
        if (!sup_s && sup_d) begin
            mem_busy <= 1'b1; // R2
            save_start <= power_loss_save_en && dirty; // R2 R3
            // A restore cut short by an outage must not reopen access
            restore_cnt <= 32'd0;
            dirty <= 1'b0;
        end else if (sup_s && !sup_d) begin
            restore_start <= 1'b1; // R5
            restore_cnt <= RESTORE_CYCLES;
            dirty <= 1'b0;
        end else if (restore_cnt != 32'd0) begin
            restore_cnt <= restore_cnt - 32'd1; // R5
            mem_busy <= (restore_cnt != 32'd1);
        end
        if (start_cond) begin
            state <= ST_DEV; // R7 R11
            bit_cnt <= 3'd0;
            addr_cnt <= 2'd0;
            sda_oe <= 1'b0;
        end else if (stop_cond) begin
            state <= ST_IDLE; // R7 R11
            sda_oe <= 1'b0;
        end else if (scl_rise && (state == ST_DEV || state == ST_ADDR || state == ST_WDATA)) begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 3'd1;
            if (bit_cnt == 3'd7) begin
                after_ack <= 1'b1;
            end
        end else if (scl_rise && state == ST_RACK) begin
            is_read <= !sda_s; // R19
        end else if (scl_fall && after_ack) begin
            // Acknowledge by default; every refusal below takes it back
            after_ack <= 1'b0;
            sda_oe <= 1'b1;
            sda_out <= 1'b0;
            state <= ST_ACK;
            case (state)
                ST_DEV: begin
                    if (mem_busy || (shreg[7:1] != `NVIA_ARRAY_DEVID &&
                        shreg[7:1] != `NVIA_CTRL_DEVID)) begin
                        sda_oe <= 1'b0;
                        state <= ST_IGNORE; // R8
                    end else begin
                        is_ctrl <= (shreg[7:1] == `NVIA_CTRL_DEVID);
                        is_read <= shreg[0]; // R6
                    end
                end
                ST_ADDR: begin
                    if (!is_ctrl && addr_cnt == 2'd0) begin
                        addr_hold[12:8] <= shreg[4:0]; // R22
                        addr_cnt <= 2'd1;
                    end else if (is_ctrl && !reg_exists(shreg)) begin
                        sda_oe <= 1'b0;
                        state <= ST_IGNORE; // R10 R13
                    end else begin
                        if (is_ctrl) begin
                            reg_ptr <= shreg; // R21
                        end else begin
                            arr_ptr <= wr_addr; // R21
                        end
                        addr_cnt <= 2'd2;
                    end
                end
                ST_WDATA: begin
                    if (wp_s) begin
                        sda_oe <= 1'b0;
                        state <= ST_IGNORE; // R1 R11
                    end else if (is_ctrl) begin
                        if (reg_ptr == `NVIA_REG_CMD) begin
                            if (shreg == `NVIA_CMD_SAVE) save_start <= 1'b1; // R25
                            if (shreg == `NVIA_CMD_RESTORE) restore_start <= 1'b1; // R25
                            if (shreg == `NVIA_CMD_SLEEP) sleep_req <= 1'b1; // R25
                            if (shreg == `NVIA_CMD_PLS_EN) power_loss_save_en <= 1'b1;
                            if (shreg == `NVIA_CMD_PLS_DIS) power_loss_save_en <= 1'b0; // R4
                            if (shreg == `NVIA_CMD_SAVE || shreg == `NVIA_CMD_RESTORE) begin
                                dirty <= 1'b0;
                            end
                        end else if (reg_ptr == `NVIA_REG_MEMCTL) begin
                            memctl <= {1'b0, shreg[`NVIA_MEMCTL_LOCK] | lock, 2'b00,
                                shreg[`NVIA_MEMCTL_BG_HI:`NVIA_MEMCTL_BG_LO], 2'b00};
                            reg_ptr <= reg_next(reg_ptr);
                        end else if (lock || reg_ptr >= `NVIA_REG_ID_FIRST) begin
                            sda_oe <= 1'b0;
                            state <= ST_IGNORE; // R12 R24
                        end else begin
                            serial_no[reg_ptr[3:0]] <= shreg;
                            reg_ptr <= reg_next(reg_ptr);
                        end
                    end else if (arr_guarded(arr_ptr, guard) || !fifo_in_ready) begin
                        sda_oe <= 1'b0;
                        state <= ST_IGNORE; // R9
                    end else begin
                        fifo_in_valid <= 1'b1; // R14
                        fifo_in_data <= shreg;
                        commit_addr <= arr_ptr;
                        dirty <= 1'b1;
                        arr_ptr <= (arr_ptr == `NVIA_ARRAY_LAST) ? `NVIA_ADDR_ZERO :
                            arr_ptr + 13'h0001; // R20
                    end
                end
                default: begin
                    sda_oe <= 1'b0;
                    state <= ST_IGNORE;
                end
            endcase
        end else if (scl_fall && state == ST_ACK) begin
            bit_cnt <= 3'd0;
            if (is_read) begin
                if (is_ctrl && !reg_exists(reg_ptr) || is_ctrl && reg_ptr == `NVIA_REG_CMD) begin
                    reg_ptr <= `NVIA_REG_MEMCTL; // R18
                end
                sda_oe <= 1'b1; // R16
                sda_out <= 1'b0;
                state <= ST_RDATA;
            end else begin
                sda_oe <= 1'b0;
                state <= (addr_cnt == 2'd2) ? ST_WDATA : ST_ADDR; // R7
            end
        end else if (state == ST_RDATA && sda_oe && scl_fall) begin
            bit_cnt <= bit_cnt + 3'd1;
            if (bit_cnt == 3'd7) begin
                sda_oe <= 1'b0;
                state <= ST_RACK;
                if (is_ctrl) begin
                    reg_ptr <= reg_next(reg_ptr); // R17
                end else begin
                    arr_ptr <= (arr_ptr == `NVIA_ARRAY_LAST) ? `NVIA_ADDR_ZERO :
                        arr_ptr + 13'h0001; // R17
                end
            end
        end else if (state == ST_RACK && scl_fall) begin
            bit_cnt <= 3'd0;
            state <= is_read ? ST_RDATA : ST_IGNORE; // R19
            sda_oe <= is_read;
        end
        if (state == ST_RDATA && sda_oe && !scl_s) begin
            sda_out <= rd_byte[3'd7 - bit_cnt]; // R16
        end
    end
end
endmodule // nvia_slave
`default_nettype wire

// ### pkg/nvia_map.vh
/*
 Constants of the serial nonvolatile SRAM target: addresses, control map, commands, timing.
 Assumes inclusion by the design files and the bench; definitions, no logic.
*/
`ifndef NVIA_MAP_VH
`define NVIA_MAP_VH
`define NVIA_CLK_MHZ 100
`define NVIA_RESTORE_US 20
`define NVIA_RESTORE_CYC (`NVIA_RESTORE_US * `NVIA_CLK_MHZ)
`define NVIA_ARRAY_DEVID 7'h50
`define NVIA_CTRL_DEVID 7'h18
`define NVIA_ARRAY_LAST 13'h1FFF
`define NVIA_Q1_BASE 13'h1800
`define NVIA_Q2_BASE 13'h1000
`define NVIA_ADDR_ZERO 13'h0000
`define NVIA_REG_MEMCTL 8'h00
`define NVIA_REG_SN_FIRST 8'h01
`define NVIA_REG_SN_LAST 8'h08
`define NVIA_REG_ID_FIRST 8'h09
`define NVIA_REG_ID_LAST 8'h0C
`define NVIA_REG_CMD 8'hAA
`define NVIA_CMD_SAVE 8'h3C
`define NVIA_CMD_RESTORE 8'h60
`define NVIA_CMD_PLS_EN 8'h59
`define NVIA_CMD_PLS_DIS 8'h19
`define NVIA_CMD_SLEEP 8'hB9
`define NVIA_MEMCTL_LOCK 6
`define NVIA_MEMCTL_BG_HI 3
`define NVIA_MEMCTL_BG_LO 2
// Identity word: value is arbitrary and names no real part
`define NVIA_DEVICE_ID 32'h12345678
`define NVIA_FIFO_WIDTH 8
`define NVIA_FIFO_DEPTH 16
`define NVIA_FIFO_AW 4
`endif

// ### rtl/nvia_sync.v
/*
 Two-flip-flop synchroniser for one asynchronous level.
 Assumes a single clock; the first stage is read only by the second.
*/
`timescale 1ns/1ps
`default_nettype none
module nvia_sync (
    input wire ref_clk,
    input wire rst,
    input wire d,
    output reg q
);
reg meta;
always @(posedge ref_clk) begin
    if (rst) begin
        meta <= 1'b1;
        q <= 1'b1;
    end else begin
        meta <= d;
        q <= meta;
    end
end
endmodule // nvia_sync
`default_nettype wire

// ### rtl/nvia_fifo.v
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock; full and empty are exact.
*/
`timescale 1ns/1ps
`default_nettype none
module nvia_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire ref_clk,
    input wire rst,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW:0] wr_ptr;
reg [AW:0] rd_ptr;
wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
wire empty = (wr_ptr == rd_ptr);
assign in_ready = !full;
assign out_valid = !empty;
assign out_data = mem[rd_ptr[AW-1:0]];
always @(posedge ref_clk) begin
    if (in_valid && !full) begin
        mem[wr_ptr[AW-1:0]] <= in_data;
    end
end
always @(posedge ref_clk) begin
    if (rst) begin
        wr_ptr <= {(AW+1){1'b0}};
        rd_ptr <= {(AW+1){1'b0}};
    end else begin
        if (in_valid && !full) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
        if (out_ready && !empty) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end
end
endmodule // nvia_fifo
`default_nettype wire

// ### verif/nvia_master.sv
/*
 I2C bus master model: start, stop, byte out with ACK sample, byte in with ACK/NACK.
 Assumes the bench resolves the open-drain SDA wire with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module nvia_master (
    input wire logic ref_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Eighths of the 160 ns SCL period
    task automatic w(input int n);
        repeat (2 * n) @(negedge ref_clk);
    endtask
    // SDA moves late in the low phase, clear of the target's sync delay on SCL
    task automatic start;
        w(3);
        sda_low = 1'b0;
        w(1);
        scl = 1'b1;
        w(2);
        sda_low = 1'b1;
        w(2);
        scl = 1'b0;
    endtask
    task automatic stop;
        w(3);
        sda_low = 1'b1;
        w(1);
        scl = 1'b1;
        w(2);
        sda_low = 1'b0;
        w(4);
    endtask
    task automatic bit_io(input logic b, output logic r);
        w(3);
        sda_low = ~b;
        w(1);
        scl = 1'b1;
        w(2);
        r = sda;
        w(2);
        scl = 1'b0;
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask
endmodule // nvia_master
`default_nettype wire

// ### verif/nvia_slave_sva.sv
/*
 Port checker for nvia_slave: reset state, pulses, power events, SDA timing.
 Assumes binding to nvia_slave; the SCL low phase outlasts the sync delay.
*/
`timescale 1ns/1ps
`default_nettype none
module nvia_slave_sva #(
    parameter RESTORE_CYCLES = 2000
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic write_protect,
    input wire logic supply_ok,
    input wire logic mem_busy,
    input wire logic save_start,
    input wire logic restore_start,
    input wire logic sleep_req,
    input wire logic power_loss_save_en
);
    logic [15:0] busy_cnt;
    // Counts from the supply rise; saturates so it cannot wrap
    always @(posedge ref_clk) begin
        if (rst || !mem_busy || !supply_ok) busy_cnt <= 16'h0000;
        else if (busy_cnt != 16'hFFFF) busy_cnt <= busy_cnt + 16'h0001;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_reset_state: assert property ($fell(rst) |-> mem_busy && power_loss_save_en && !sda_oe)
        else $error("reset state wrong");
    a_restore_rise: assert property ($rose(supply_ok) |-> ##[1:8] restore_start)
        else $error("no restore after supply rise");
    a_busy_min: assert property ($fell(mem_busy) |-> $past(busy_cnt) >= RESTORE_CYCLES - 1)
        else $error("access enabled too early");
    a_busy_on_loss: assert property ($fell(supply_ok) |-> ##[1:8] mem_busy)
        else $error("access not blocked on supply loss");
    a_save_pulse: assert property (save_start |=> !save_start)
        else $error("save pulse too long");
    a_restore_pulse: assert property (restore_start |=> !restore_start)
        else $error("restore pulse too long");
    a_sleep_pulse: assert property (sleep_req |=> !sleep_req)
        else $error("sleep pulse too long");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("SDA enable moved with SCL high");
    a_data_scl_low: assert property (sda_oe && $past(sda_oe) && $changed(sda_out) |-> !scl_in)
        else $error("SDA data moved with SCL high");
endmodule // nvia_slave_sva
bind nvia_slave nvia_slave_sva #(.RESTORE_CYCLES(RESTORE_CYCLES)) u_sva (
    .ref_clk(ref_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .write_protect(write_protect),
    .supply_ok(supply_ok), .mem_busy(mem_busy), .save_start(save_start),
    .restore_start(restore_start), .sleep_req(sleep_req),
    .power_loss_save_en(power_loss_save_en));
`default_nettype wire

// ### verif/test_nvram_i2c_slave_access.sv
/*
 Self-checking bench for nvia_slave: command rows, then array, guard, control and power tests.
 Assumes nvia_master on the bus and a pulled-up SDA wire.
*/
`timescale 1ns/1ps
`default_nettype none
`include "nvia_map.vh"
module test_nvram_i2c_slave_access;
    localparam int RC = 20;
    localparam logic [6:0] ARR = `NVIA_ARRAY_DEVID;
    localparam logic [6:0] CTL = `NVIA_CTRL_DEVID;
    localparam logic [31:0] DEV_ID = `NVIA_DEVICE_ID;
    logic ref_clk = 1'b0;
    logic rst, write_protect, supply_ok, scl, m_low, sda_out, sda_oe;
    logic mem_busy, save_start, restore_start, sleep_req, pls_en, a1;
    wire sda;
    int bad_count = 0, tests_run = 0, cycles = 0, n_save = 0, n_rest = 0, n_sleep = 0;
    int s0, r0, c, g;
    logic [5:0] ak;
    logic [39:0] d;
    logic [10:0] rows [4];
    logic [12:0] probes [3];
    assign sda = ~(m_low | (sda_oe & ~sda_out));
    nvia_master m (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(m_low));
    nvia_slave #(.RESTORE_CYCLES(RC)) dut (
        .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .write_protect(write_protect),
        .supply_ok(supply_ok), .mem_busy(mem_busy), .save_start(save_start),
        .restore_start(restore_start), .sleep_req(sleep_req), .power_loss_save_en(pls_en));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic results;
        if (bad_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (save_start === 1'b1) n_save <= n_save + 1;
        if (restore_start === 1'b1) n_rest <= n_rest + 1;
        if (sleep_req === 1'b1) n_sleep <= n_sleep + 1;
        if (cycles == 60000) begin
            bad_count++;
            results();
        end
    end
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bit 0 of a is the device-id ACK, bit i+1 the ACK of byte i
    task automatic wr(input logic [6:0] id, input logic [39:0] b, input int n,
                      input logic rs, output logic [5:0] a);
        a = 6'h00;
        m.start();
        m.send({id, 1'b0}, a[0]);
        for (int i = 0; i < n; i++) m.send(b[39 - 8 * i -: 8], a[i + 1]);
        if (!rs) m.stop();
    endtask
    task automatic rd(input logic [6:0] id, input int n, output logic [39:0] v, output logic a);
        logic [7:0] x;
        v = 40'h0;
        m.start();
        m.send({id, 1'b1}, a);
        for (int i = 0; i < n; i++) begin
            m.recv(i == n - 1, x);
            v = {v[31:0], x};
        end
        m.stop();
    endtask
    task automatic wait_ready(output int n);
        n = 0;
        while (mem_busy !== 1'b0 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        chk(mem_busy, 1'b0);
    endtask
    initial begin
        rst = 1'b1;
        write_protect = 1'b0;
        supply_ok = 1'b0;
        rows = '{{`NVIA_CMD_SAVE, 3'b101}, {`NVIA_CMD_RESTORE, 3'b011},
                 {`NVIA_CMD_PLS_DIS, 3'b000}, {`NVIA_CMD_PLS_EN, 3'b001}};
        probes = '{13'h0FFF, 13'h17FF, 13'h1800};
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        chk({mem_busy, pls_en, sda_oe}, 3'b110);
        rd(ARR, 1, d, a1);
        chk(a1, 1'b0);
        supply_ok = 1'b1;
        wait_ready(c);
        chk(c >= RC, 1'b1);
        rd(7'h33, 1, d, a1);
        chk(a1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            s0 = n_save;
            r0 = n_rest;
            wr(CTL, {8'hAA, rows[i][10:3], 24'h0}, 2, 1'b0, ak);
            chk({ak[2:0], n_save != s0, n_rest != r0, pls_en}, {3'b111, rows[i][2:0]});
        end
        // Top three address bits are don't-care, so 0xFFFF lands on the last byte
        wr(ARR, {16'hFFFF, 24'hA1A2A3}, 5, 1'b0, ak);
        chk(ak, 6'h3F);
        wr(ARR, {16'h1FFF, 24'h0}, 2, 1'b1, ak);
        rd(ARR, 2, d, a1);
        chk({ak[2:0], a1, d[15:0]}, {4'hF, 16'hA1A2});
        rd(ARR, 1, d, a1);
        chk({a1, d[7:0]}, {1'b1, 8'hA3});
        wr(ARR, {16'h0010, 8'h11, 16'h0}, 3, 1'b0, ak);
        write_protect = 1'b1;
        wr(ARR, {16'h0010, 16'h2233, 8'h0}, 4, 1'b0, ak);
        chk(ak[4:0], 5'b00111);
        write_protect = 1'b0;
        // Stop after four data bits: nothing may land
        wr(ARR, {16'h0010, 24'h0}, 2, 1'b1, ak);
        for (int i = 0; i < 4; i++) m.bit_io(1'b0, a1);
        m.stop();
        wr(ARR, {16'h0010, 24'h0}, 2, 1'b1, ak);
        rd(ARR, 1, d, a1);
        chk(d[7:0], 8'h11);
        for (g = 0; g < 4; g++) begin
            wr(CTL, {8'h00, 4'h0, g[1:0], 2'b00, 24'h0}, 2, 1'b0, ak);
            for (int p = 0; p < 3; p++) begin
                wr(ARR, {3'b000, probes[p], 8'h5A, 16'h0}, 3, 1'b0, ak);
                chk(ak[3], g + p <= 2);
            end
        end
        wr(CTL, {16'h0000, 24'h0}, 2, 1'b0, ak);
        rd(ARR, 1, d, a1);
        chk(d[7:0], 8'h5A);
        wr(CTL, {8'h0D, 32'h0}, 2, 1'b0, ak);
        chk(ak[2:0], 3'b001);
        wr(CTL, {8'h08, 16'h5A77, 16'h0}, 3, 1'b0, ak);
        chk(ak[3:0], 4'b0111);
        rd(CTL, 1, d, a1);
        chk(d[7:0], DEV_ID[31:24]);
        wr(CTL, {8'h0C, 32'h0}, 1, 1'b1, ak);
        rd(CTL, 2, d, a1);
        chk(d[15:0], {DEV_ID[7:0], 8'h00});
        // The lock cannot be cleared, so it comes after all serial-number writes
        wr(CTL, {16'h0040, 24'h0}, 2, 1'b0, ak);
        wr(CTL, {16'h0199, 24'h0}, 2, 1'b0, ak);
        chk(ak[2:0], 3'b011);
        wr(CTL, {16'h0040, 24'h0}, 2, 1'b0, ak);
        chk(ak[2:0], 3'b111);
        s0 = n_save;
        supply_ok = 1'b0;
        repeat (40) @(negedge ref_clk);
        chk({n_save - s0, mem_busy}, {32'd1, 1'b1});
        rd(ARR, 1, d, a1);
        chk(a1, 1'b0);
        supply_ok = 1'b1;
        wait_ready(c);
        s0 = n_save;
        supply_ok = 1'b0;
        repeat (40) @(negedge ref_clk);
        chk(n_save - s0, 0);
        supply_ok = 1'b1;
        wait_ready(c);
        s0 = n_sleep;
        wr(CTL, {8'hAA, `NVIA_CMD_SLEEP, 24'h0}, 2, 1'b0, ak);
        chk({ak[2:0], n_sleep - s0}, {3'b111, 32'd1});
        results();
    end
endmodule // test_nvram_i2c_slave_access
`default_nettype wire
